/* File: rtl/fpas_ctrl.sv */
// host controller that runs lock, unprotect, abort and status sequences on the flash
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fpas_ctrl import fpas_pkg::*; #(
  parameter int MAX_RETRY = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [FL_AW-1:0] flash_addr,
  input wire logic [FL_DW-1:0] flash_dq_i,
  output logic [FL_DW-1:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_vpp_en
);

  // ----------------------------------------------------------------------------
  // sequence table
  // ----------------------------------------------------------------------------
  // one step of the selected operation; the sector address rides in sa
  function automatic fpas_step_t step_f(input logic [3:0] op, input logic [3:0] idx,
                                        input logic [FL_AW-1:0] sa);
    fpas_step_t s;
    logic [FL_AW-1:0] va;
    s = '{kind: K_END, addr: '0, data: '0};
    va = {sa[FL_AW-1:8], ID_PROT_LOW};
    case (op)
      OP_LOCK, OP_UNPROT: begin
        // six-cycle lock / unprotect, then poll, verify, reset
        case (idx)
          4'h0, 4'h3: s = '{kind: K_WR, addr: UNL1_ADDR, data: UNL1_DATA};
          4'h1, 4'h4: s = '{kind: K_WR, addr: UNL2_ADDR, data: UNL2_DATA};
          4'h2: s = '{kind: K_WR, addr: UNL1_ADDR, data: CMD_SETUP};
          4'h5: s = '{kind: K_WR, addr: sa, data: (op == OP_LOCK) ? CMD_LOCK : CMD_UNPROT};
          4'h6: s = '{kind: K_POLL, addr: sa, data: '0};
          4'h7: s = '{kind: K_WR, addr: sa, data: CMD_RDID};
          4'h8: s = '{kind: K_VFY, addr: va, data: '0};
          4'h9: s = '{kind: K_WR, addr: sa, data: CMD_RDARRAY};
          default: s = '{kind: K_END, addr: '0, data: '0};
        endcase
      end
      OP_ABORT: begin
        // three-cycle abort, then leave abort and clear fail bits
        case (idx)
          4'h0: s = '{kind: K_WR, addr: UNL1_ADDR, data: UNL1_DATA};
          4'h1: s = '{kind: K_WR, addr: UNL2_ADDR, data: UNL2_DATA};
          4'h2: s = '{kind: K_WR, addr: UNL1_ADDR, data: CMD_ABORT};
          4'h3: s = '{kind: K_WR, addr: sa, data: CMD_RDARRAY};
          4'h4: s = '{kind: K_WR, addr: sa, data: CMD_CLRSTAT};
          default: s = '{kind: K_END, addr: '0, data: '0};
        endcase
      end
      OP_RDSTAT, OP_RDID, OP_RDARRAY: begin
        // command write, one read, and for read id leave id mode afterwards
        case (idx)
          4'h0: s = '{kind: K_WR, addr: sa,
                      data: (op == OP_RDSTAT) ? CMD_RDSTAT :
                            (op == OP_RDID) ? CMD_RDID : CMD_RDARRAY};
          4'h1: s = '{kind: (op == OP_RDSTAT) ? K_POLL : K_RD, addr: sa, data: '0};
          4'h2: s = '{kind: (op == OP_RDID) ? K_WR : K_END, addr: sa, data: CMD_RDARRAY};
          default: s = '{kind: K_END, addr: '0, data: '0};
        endcase
      end
      OP_CLRSTAT: begin
        if (idx == 4'h0) begin
          s = '{kind: K_WR, addr: sa, data: CMD_CLRSTAT};
        end
      end
      default: s = '{kind: K_END, addr: '0, data: '0};
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------------------
  // register bus state
  // ----------------------------------------------------------------------------
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d; // captured halves of a write
  logic [4:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic go_q, go_d; // one-cycle start pulse
  logic [3:0] op_q, op_d; // operation to run
  logic [FL_AW-1:0] sect_q, sect_d; // flash / sector address

  // sequencer state, declared here for the status read
  fpas_state_t state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] retry_q, retry_d;
  logic [7:0] fstat_q, fstat_d; // last masked flash status
  logic [FL_DW-1:0] frd_q, frd_d; // last word read
  logic done_q, done_d, vfail_q, vfail_d;
  logic [FL_AW-1:0] addr_q, addr_d;
  logic [FL_DW-1:0] dqo_q, dqo_d;
  logic dqoe_q, dqoe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, vpp_q, vpp_d;
  fpas_step_t cur;

  // bus slave: writes when both halves are in, reads in one beat
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    go_d = 1'b0;
    op_d = op_q;
    sect_d = sect_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // both halves present: perform the write
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case ({waddr_q[4:2], 2'b00})
        OFS_CTRL: begin
          // start is ignored while a sequence runs
          if (state_q == S_IDLE && wdata_q[3:0] != OP_NONE) begin
            go_d = 1'b1;
            op_d = wdata_q[3:0];
          end
        end
        OFS_ADDR: begin
          if (state_q == S_IDLE) begin
            sect_d = wdata_q[FL_AW-1:0];
          end
        end
        OFS_STAT, OFS_RDATA: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case ({s_axi_araddr[4:2], 2'b00})
        OFS_CTRL: rdata_d[3:0] = op_q;
        OFS_ADDR: rdata_d[FL_AW-1:0] = sect_q;
        OFS_STAT: begin
          rdata_d[7:0] = fstat_q;
          rdata_d[STAT_BUSY] = (state_q != S_IDLE);
          rdata_d[STAT_DONE] = done_q;
          rdata_d[STAT_VFAIL] = vfail_q;
        end
        OFS_RDATA: rdata_d[FL_DW-1:0] = frd_q;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      go_q <= 1'b0;
      op_q <= OP_NONE;
      sect_q <= '0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      go_q <= go_d;
      op_q <= op_d;
      sect_q <= sect_d;
    end
  end

  // ----------------------------------------------------------------------------
  // flash sequencer
  // ----------------------------------------------------------------------------
  assign cur = step_f(op_q, idx_q, sect_q);

  // walks the step table, one chip-select pulse per step
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    retry_d = retry_q;
    fstat_d = fstat_q;
    frd_d = frd_q;
    done_d = done_q;
    vfail_d = vfail_q;
    addr_d = addr_q;
    dqo_d = dqo_q;
    dqoe_d = dqoe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    vpp_d = vpp_q;
    case (state_q)
      S_IDLE: begin
        if (go_q) begin
          state_d = S_ISSUE;
          idx_d = '0;
          retry_d = '0;
          done_d = 1'b0;
          vfail_d = 1'b0;
          vpp_d = (op_q == OP_LOCK) || (op_q == OP_UNPROT);
        end
      end
      S_ISSUE: begin
        cnt_d = '0;
        addr_d = cur.addr;
        if (cur.kind == K_END) begin
          state_d = S_IDLE;
          done_d = 1'b1;
          vpp_d = 1'b0;
        end else if (cur.kind == K_WR) begin
          dqo_d = {{(FL_DW-8){1'b0}}, cur.data};
          dqoe_d = 1'b1;
          ce_n_d = 1'b0;
          state_d = S_WLO;
        end else begin
          oe_n_d = 1'b0;
          ce_n_d = 1'b0;
          state_d = S_RLO;
        end
      end
      S_WLO: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == WC_LAST) begin
          ce_n_d = 1'b1;
          cnt_d = '0;
          state_d = S_WHI;
        end
      end
      S_WHI: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == WC_LAST) begin
          dqoe_d = 1'b0;
          idx_d = idx_q + 4'h1;
          state_d = S_ISSUE;
        end
      end
      S_RLO: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == ACC_LAST) begin
          frd_d = flash_dq_i;
          if (cur.kind == K_POLL) begin
            fstat_d = flash_dq_i[7:0] & STAT_MASK;
          end
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d = '0;
          state_d = S_RHI;
        end
      end
      S_RHI: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == WC_LAST) begin
          state_d = S_ISSUE;
          idx_d = idx_q + 4'h1;
          if (cur.kind == K_POLL && !fstat_q[SB_READY]) begin
            idx_d = idx_q;
          end
          if (cur.kind == K_VFY && (frd_q[0] != (op_q == OP_LOCK))) begin
            if (retry_q < 2'(MAX_RETRY)) begin
              retry_d = retry_q + 2'h1;
              idx_d = '0;
            end else begin
              vfail_d = 1'b1;
            end
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // sequencer and pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      idx_q <= '0;
      cnt_q <= '0;
      retry_q <= '0;
      fstat_q <= '0;
      frd_q <= '0;
      done_q <= 1'b0;
      vfail_q <= 1'b0;
      addr_q <= '0;
      dqo_q <= '0;
      dqoe_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      vpp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      retry_q <= retry_d;
      fstat_q <= fstat_d;
      frd_q <= frd_d;
      done_q <= done_d;
      vfail_q <= vfail_d;
      addr_q <= addr_d;
      dqo_q <= dqo_d;
      dqoe_q <= dqoe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      vpp_q <= vpp_d;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign flash_addr = addr_q;
  assign flash_dq_o = dqo_q;
  assign flash_dq_oe = dqoe_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_vpp_en = vpp_q;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  no_contention_a: assert property (!(dqoe_q && !oe_n_q))
    else $error("data driven while output gate low");
  vpp_on_lock_a: assert property ($fell(ce_n_q) && dqoe_q &&
    (dqo_q[7:0] == CMD_LOCK || dqo_q[7:0] == CMD_UNPROT) |-> vpp_q)
    else $error("lock code written without program supply");
  data_hold_a: assert property ($rose(ce_n_q) && $past(dqoe_q) |->
    dqoe_q && $stable(dqo_q))
    else $error("write data not held across rising select");
  addr_hold_a: assert property (!ce_n_q && $past(!ce_n_q) |-> $stable(addr_q))
    else $error("address moved while select low");
  status_mask_a: assert property (fstat_q[6] == 1'b0 && fstat_q[2] == 1'b0)
    else $error("spare status bits kept");
  select_width_a: assert property ($fell(ce_n_q) |-> !ce_n_q[*8])
    else $error("select pulse too short");
  poll_ready_a: assert property (state_q == S_RHI && cur.kind == K_POLL &&
    idx_d != idx_q |-> fstat_q[SB_READY])
    else $error("poll left before ready");
  bresp_hold_a: assert property (bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");
  rdata_hold_a: assert property (rvalid_q && !s_axi_rready |=> rvalid_q && $stable(rdata_q))
    else $error("read data dropped");

  lock_run_c: cover property (go_q && op_q == OP_LOCK ##[1:1000] done_q);
  abort_run_c: cover property (go_q && op_q == OP_ABORT ##[1:1000] done_q);
  retry_c: cover property (retry_q == 2'h1);
  repoll_c: cover property (state_q == S_RHI && cur.kind == K_POLL && !fstat_q[SB_READY]);

endmodule // fpas_ctrl
`default_nettype wire

/* File: rtl/fpas_pkg.sv */
// constants, types and step encodings for the flash protect/abort host controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
package fpas_pkg;

  // ----------------------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------------------
  localparam int FL_AW = 21; // flash address width
  localparam int FL_DW = 16; // flash data width
  localparam int CLK_NS = 8; // aclk period
  localparam int T_WC_NS = 120; // least write cycle time
  localparam int T_ACC_NS = 120; // slowest access time
  localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS; // select low and high phase
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS; // read sample delay
  localparam logic [4:0] WC_LAST = 5'(WC_CYC - 1);
  localparam logic [4:0] ACC_LAST = 5'(ACC_CYC - 1);

  // ----------------------------------------------------------------------------
  // register map of the controller
  // ----------------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00; // write: operation code
  localparam logic [4:0] OFS_ADDR = 5'h04; // flash / sector address
  localparam logic [4:0] OFS_STAT = 5'h08; // controller and flash status
  localparam logic [4:0] OFS_RDATA = 5'h0C; // last data read from flash
  localparam int STAT_BUSY = 8; // field positions in the status word
  localparam int STAT_DONE = 9;
  localparam int STAT_VFAIL = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------------
  // flash status bits and command codes
  // ----------------------------------------------------------------------------
  localparam int SB_READY = 7; // ready_flag
  localparam int SB_PROTECT = 3; // protect_flag
  localparam logic [7:0] STAT_MASK = 8'hBB; // drops spare bits six and two
  localparam logic [7:0] CMD_LOCK = 8'h20;
  localparam logic [7:0] CMD_UNPROT = 8'h40;
  localparam logic [7:0] CMD_ABORT = 8'hE0;
  localparam logic [7:0] CMD_SETUP = 8'h60;
  localparam logic [7:0] CMD_RDARRAY = 8'hFF;
  localparam logic [7:0] CMD_RDSTAT = 8'h70;
  localparam logic [7:0] CMD_CLRSTAT = 8'h50;
  localparam logic [7:0] CMD_RDID = 8'h90;
  localparam logic [7:0] UNL1_DATA = 8'hAA;
  localparam logic [7:0] UNL2_DATA = 8'h55;
  localparam logic [FL_AW-1:0] UNL1_ADDR = 21'h005555;
  localparam logic [FL_AW-1:0] UNL2_ADDR = 21'h002AAA;
  localparam logic [7:0] ID_PROT_LOW = 8'h02; // id-mode address of the lock bit

  // ----------------------------------------------------------------------------
  // operations that software may start
  // ----------------------------------------------------------------------------
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_LOCK = 4'h1;
  localparam logic [3:0] OP_UNPROT = 4'h2;
  localparam logic [3:0] OP_ABORT = 4'h3;
  localparam logic [3:0] OP_RDSTAT = 4'h4;
  localparam logic [3:0] OP_RDID = 4'h5;
  localparam logic [3:0] OP_CLRSTAT = 4'h6;
  localparam logic [3:0] OP_RDARRAY = 4'h7;

  // step kinds of a sequence
  localparam logic [2:0] K_END = 3'h0;
  localparam logic [2:0] K_WR = 3'h1;
  localparam logic [2:0] K_RD = 3'h2;
  localparam logic [2:0] K_POLL = 3'h3;
  localparam logic [2:0] K_VFY = 3'h4;

  // one bus step of a command sequence
  typedef struct packed {
    logic [2:0] kind;
    logic [FL_AW-1:0] addr;
    logic [7:0] data;
  } fpas_step_t;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ISSUE = 6'h02,
    S_WLO = 6'h04,
    S_WHI = 6'h08,
    S_RLO = 6'h10,
    S_RHI = 6'h20
  } fpas_state_t;

endpackage
`default_nettype wire

/* File: dv/fpas_flash_model.sv */
// behavioural flash device answering the protect/abort controller
`timescale 1ns/1ps
`default_nettype none
module fpas_flash_model import fpas_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h3C // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [FL_AW-1:0] flash_addr,
  input wire logic [FL_DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_vpp_en,
  output logic [FL_DW-1:0] flash_dq_i,
  input wire logic [1:0] bg_op,
  input wire logic stubborn,
  input wire logic [7:0] busy_len
);
  logic ce_q, rd_q, ef_q, pf_q, pend_q, rdy, rd;
  logic [1:0] mode_q, bg_q, lk_q; // mode: array, status, id, abort
  logic [2:0] seq_q;
  logic [8:0] bsy_q;
  logic [FL_AW-1:0] sa_q;
  logic [7:0] st_q, c, stat;
  logic [FL_DW-1:0] last_q, val;
  assign rd = !flash_ce_n && !flash_oe_n;
  assign c = flash_dq_o[7:0];
  assign rdy = bsy_q == 9'd0 && bg_q == 2'd0;
  assign stat = {rdy, 1'b0, ef_q, pf_q, |lk_q, 3'b000};
  always_comb begin
    val = flash_addr[15:0] ^ 16'h5A5A;
    if (mode_q == 2'd2) begin
      val = {15'h0, flash_addr[20:16] == 5'h00 ? lk_q[0] : flash_addr[20:16] == 5'h1F && lk_q[1]};
      if (flash_addr[7:0] == 8'h00) val = {8'h00, MAKER_ID};
      if (flash_addr[7:0] == 8'h01) val = {8'h00, PART_ID};
    end else if (mode_q != 2'd0) val = {8'h00, st_q};
  end
  // released bus shows the inverse of its last value
  assign flash_dq_i = rd ? val : ~last_q;
  always_ff @(posedge aclk) begin
    ce_q <= flash_ce_n;
    rd_q <= rd;
    if (rd) last_q <= val;
    if (rd && !rd_q) st_q <= stat;
    if (ce_q && !flash_ce_n) sa_q <= flash_addr;
    if (!aresetn) begin
      ef_q <= 1'b0;
      pf_q <= 1'b0;
      mode_q <= 2'd0;
      bg_q <= 2'd0;
      lk_q <= 2'd0;
      seq_q <= 3'd0;
      bsy_q <= 9'd0;
    end else begin
      if (bg_op != 2'd0) bg_q <= bg_op;
      if (bsy_q != 9'd0) bsy_q <= bsy_q - 9'd1;
      // lock bit changes as busy ends
      if (bsy_q == 9'd1 && !stubborn && (sa_q[20:16] == 5'h00 || sa_q[20:16] == 5'h1F))
        lk_q[sa_q[20]] <= pend_q;
      // command at rising select, bad value discards
      if (!ce_q && flash_ce_n && flash_dq_oe) begin
        seq_q <= 3'd0;
        case (seq_q)
          3'd0, 3'd3: if (c == UNL1_DATA && sa_q == UNL1_ADDR) seq_q <= seq_q + 3'd1;
          3'd1, 3'd4: if (c == UNL2_DATA && sa_q == UNL2_ADDR) seq_q <= seq_q + 3'd1;
          3'd2: if (c == CMD_SETUP) seq_q <= 3'd3;
          3'd5: if (flash_vpp_en && (c == CMD_LOCK || c == CMD_UNPROT)) begin
            bsy_q <= {1'b0, busy_len} + 9'd1;
            pend_q <= c == CMD_LOCK;
            mode_q <= 2'd1;
          end
          default: ;
        endcase
        // abort halts only a running program or erase
        if (seq_q == 3'd2 && c == CMD_ABORT && bg_q != 2'd0) begin
          ef_q <= ef_q | bg_q[1];
          pf_q <= pf_q | bg_q[0];
          bg_q <= 2'd0;
          mode_q <= 2'd3;
        end
        if (seq_q == 3'd0) begin
          if (c == CMD_RDSTAT) mode_q <= 2'd1;
          if (c == CMD_RDID) mode_q <= 2'd2;
          if (c == CMD_RDARRAY) mode_q <= 2'd0;
          if (c == CMD_CLRSTAT) ef_q <= 1'b0;
          if (c == CMD_CLRSTAT) pf_q <= 1'b0;
        end
      end
    end
  end
endmodule // fpas_flash_model
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the flash protect/abort controller
`timescale 1ns/1ps
`default_nettype none
module tb import fpas_pkg::*;;
  localparam int RETRY = 2;
  localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
  localparam logic [7:0] PART = 8'h3C; // arbitrary value
  logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stubborn = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ce_d;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_vpp_en;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bg_op = 2'b00;
  logic [7:0] busy_len = 8'h10;
  logic [FL_AW-1:0] flash_addr, sa;
  logic [FL_DW-1:0] flash_dq_i, flash_dq_o;
  int n_errors = 0, total_checks = 0, cyc = 0, n_lock = 0;
  fpas_ctrl #(.MAX_RETRY(RETRY)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_vpp_en);
  fpas_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) model (.aclk, .aresetn, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_vpp_en, .flash_dq_i, .bg_op,
    .stubborn, .busy_len);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // expected status word: verify fail, done, masked ready/protect byte
  function automatic logic [31:0] stat_exp(input logic vf, input logic pr);
    return {21'h0, vf, 2'b10, 8'({4'h8, pr, 3'b000}) & STAT_MASK};
  endfunction
  function automatic logic [31:0] arr(input logic [FL_AW-1:0] a);
    return {16'h0, a[15:0] ^ 16'h5A5A};
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // start one operation, wait for done, fetch last flash data
  task automatic op(input logic [3:0] code, input logic [FL_AW-1:0] a);
    wr(OFS_ADDR, 32'(a));
    wr(OFS_CTRL, {28'h0, code});
    repeat (4) @(posedge aclk);
    rd(OFS_STAT, st);
    chk("busy", 32'h1, 32'(st[STAT_BUSY]));
    while (st[STAT_DONE] !== 1'b1) rd(OFS_STAT, st);
    rd(OFS_RDATA, rdv);
  endtask
  // lock command watch and timeout
  always @(posedge aclk) begin
    ce_d <= flash_ce_n;
    cyc++;
    if (flash_ce_n && !ce_d && flash_dq_oe && flash_dq_o[7:0] == CMD_LOCK) begin
      n_lock++;
      chk("vpp", 32'h1, 32'(flash_vpp_en));
    end
    if (cyc == 60000) begin
      n_errors++;
      $display("Error timeout expected done seen hang");
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hC3EC3C03));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(5'h10, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(rs));
    rd(5'h14, rdv);
    chk("rresp", 32'(RESP_SLVERR), 32'(rs));
    chk("rdata", 32'h0, rdv);
    $display("test map done");
    for (int i = 0; i < 2; i++) begin
      sa = {(i == 1) ? 5'h1F : 5'h00, 16'($urandom)};
      busy_len <= 8'($urandom_range(1, 200));
      op(OP_LOCK, sa);
      chk("lock stat", stat_exp(1'b0, 1'b1), st);
      op(OP_RDID, {sa[20:8], 8'h02});
      chk("lock bit", 32'h1, rdv);
      op(OP_RDID, {sa[20:8], 8'(i)});
      chk("id code", {24'h0, (i == 1) ? PART : MAKER}, rdv);
      chk("id exit", 32'h0, 32'(model.mode_q));
      op(OP_RDARRAY, sa);
      chk("array", arr(sa), rdv);
    end
    $display("test lock done");
    busy_len <= 8'h00;
    for (int i = 0; i < 2; i++) begin
      op(OP_UNPROT, {(i == 1) ? 5'h1F : 5'h00, 16'($urandom)});
      chk("unprot stat", stat_exp(1'b0, i == 0), st);
    end
    $display("test unprotect done");
    stubborn <= 1'b1;
    n_lock = 0;
    op(OP_LOCK, 21'h0);
    chk("retry stat", stat_exp(1'b1, 1'b0), st);
    chk("lock tries", 32'(RETRY + 1), 32'(n_lock));
    stubborn <= 1'b0;
    $display("test retry done");
    for (int k = 0; k < 3; k++) begin
      bg_op <= 2'(k);
      @(posedge aclk);
      bg_op <= 2'b00;
      op(OP_ABORT, 21'h0);
      chk("abort exit", 32'h0, 32'(model.mode_q));
      op(OP_RDSTAT, 21'h0);
      chk("abort stat", stat_exp(1'b0, 1'b0), st);
    end
    op(OP_CLRSTAT, 21'h0);
    chk("clear stat", stat_exp(1'b0, 1'b0), st);
    $display("test abort done");
    test_done();
  end
endmodule // tb
`default_nettype wire
